// file: logic/ecc_consts.svh
// Register map, field layout and curve constants of the point engine
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH
`define OFS_INT_RAW 12'h00c
`define OFS_INT_ST 12'h010
`define OFS_INT_ENA 12'h014
`define OFS_INT_CLR 12'h018
`define OFS_CONF 12'h01c
`define OFS_DATE 12'h0fc
`define OFS_MEM_K 12'h100
`define OFS_MEM_X 12'h120
`define OFS_MEM_Y 12'h140
`define MEM_NONE 2'h3
`define CONF_START 0
`define CONF_RESET 1
`define CONF_CURVE 2
`define CONF_CLK_EN 3
`define CONF_OP_LSB 4
`define CONF_RESULT 7
`define INT_DONE 0
// Version word, value arbitrary
`define DATE_RESET 32'h00000001
`define CURVE_192 1'b0
`define CURVE_256 1'b1
`define OP_PMUL 3'd0
`define OP_DIV 3'd1
`define OP_VER 3'd2
`define OP_VER_MUL 3'd3
`define OP_JMUL 3'd4
`define OP_RSVD 3'd5
`define OP_JVER 3'd6
`define OP_VER_JMUL 3'd7
`define TOP_192 8'd191
`define TOP_256 8'd255
`define R_K 4'h0
`define R_PX 4'h1
`define R_PY 4'h2
`define R_X 4'h3
`define R_Y 4'h4
`define R_Z 4'h5
`define R_T1 4'h6
`define R_T2 4'h7
`define R_T3 4'h8
`define N_STORE 9
`define R_0 4'hd
`define R_B 4'he
`define R_1 4'hf
`define SEG_VA 7'd0
`define SEG_VJ 7'd8
`define SEG_LOADP 7'd21
`define SEG_DBL 7'd25
`define SEG_ADD 7'd48
`define SEG_INVZ 7'd67
`define SEG_INVK 7'd70
`define SEG_SQ 7'd73
`define SEG_MB 7'd75
`define SEG_AFF 7'd77
`define SEG_STJ 7'd82
`define SEG_ZK 7'd86
`define SEG_ZXY 7'd87
`define SEG_DIVF 7'd90
`define P_192 \
  256'hfffffffffffffffffffffffffffffffeffffffffffffffff
`define B_192 \
  256'h64210519e59c80e70fa7e9ab72243049feb8deecc146b9b1
`define E_192 \
  256'hfffffffffffffffffffffffffffffffefffffffffffffffd
`define P_256 \
  256'hffffffff00000001000000000000000000000000ffffffffffffffffffffffff
`define B_256 \
  256'h5ac635d8aa3a93e7b3ebbd55769886bc651d06b0cc53b0f63bce3c3e27d2604b
`define E_256 \
  256'hffffffff00000001000000000000000000000000fffffffffffffffffffffffd
`endif

// file: logic/ecc_pkg.sv
// Shared types of the point engine
package ecc_pkg;
  typedef enum logic [1:0] {U_END, U_ADD, U_SUB, U_MUL} alu_op_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_EXEC, ST_CHECK, ST_MSTART, ST_BIT, ST_DBLD, ST_NEXT,
    ST_MEND, ST_INV, ST_INVM, ST_INVN, ST_DONE
  } engine_state_t;
endpackage

// file: logic/ecc_mod_alu.sv
// Modular add, subtract and bit-serial multiply over a prime
`timescale 1ns/1ps
`default_nettype none
module ecc_mod_alu
  import ecc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic start,
  input var alu_op_t op,
  input wire logic [255:0] a,
  input wire logic [255:0] b,
  input wire logic [255:0] modulus,
  output logic done,
  output logic [255:0] result
);
  logic [255:0] acc;
  logic [255:0] mcand;
  logic [255:0] mplier;
  logic [7:0] cnt;
  logic busy;
  logic [255:0] step;

  // Inputs must already be reduced below the modulus
  function automatic logic [255:0] mod_add(input logic [255:0] x,
                                           input logic [255:0] y,
                                           input logic [255:0] m);
    logic [256:0] s;
    s = {1'b0, x} + {1'b0, y};
    if (s >= {1'b0, m}) s = s - {1'b0, m};
    return s[255:0];
  endfunction

  function automatic logic [255:0] mod_sub(input logic [255:0] x,
                                           input logic [255:0] y,
                                           input logic [255:0] m);
    logic [256:0] d;
    d = {1'b0, x} - {1'b0, y};
    if (d[256]) d = d + {1'b0, m};
    return d[255:0];
  endfunction

  // Msb-first double and add, one multiplier bit a cycle
  always_comb begin
    step = mod_add(acc, acc, modulus);
    if (mplier[255]) step = mod_add(step, mcand, modulus);
  end

  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 8'h00;
      acc <= '0;
      mcand <= '0;
      mplier <= '0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (busy) begin
        acc <= step;
        mplier <= {mplier[254:0], 1'b0};
        cnt <= cnt - 8'h01;
        if (cnt == 8'h00) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= step;
        end
      end else if (start) begin
        unique case (op)
          U_ADD: begin
            result <= mod_add(a, b, modulus);
            done <= 1'b1;
          end
          U_SUB: begin
            result <= mod_sub(a, b, modulus);
            done <= 1'b1;
          end
          U_MUL: begin
            acc <= '0;
            mcand <= a;
            mplier <= b;
            cnt <= 8'hff;
            busy <= 1'b1;
          end
          U_END: ;
        endcase
      end
    end
  end
endmodule // ecc_mod_alu
`default_nettype wire

// file: logic/ecc_point_engine.sv
// Elliptic-curve point engine: register slave, operands, sequencer
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_consts.svh"
module ecc_point_engine
  import ecc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic calc_complete_irq
);
  logic [255:0] store [0:`N_STORE-1];
  logic curve_size_select;
  logic [2:0] operation_select;
  logic on_curve_result;
  logic clk_force;
  logic [31:0] date_word;
  logic int_raw;
  logic int_ena;
  engine_state_t state;
  engine_state_t ret_state;
  logic [6:0] pc;
  logic [6:0] post_pc;
  logic issued;
  logic inf;
  logic do_mult;
  logic jac_out;
  logic [7:0] bit_idx;
  logic [13:0] uword;
  alu_op_t alu_op;
  logic [3:0] u_dst;
  logic [255:0] opa;
  logic [255:0] opb;
  logic [255:0] alu_res;
  logic alu_done;
  logic alu_start;
  logic [255:0] p_mod;
  logic [255:0] p_exp;
  logic [7:0] top_bit;
  logic [1:0] mem_sel;
  logic mem_wr;
  logic launch;
  logic abort;
  logic launch_bit;
  logic done_pulse;
  logic ver_eq;
  logic kbit;
  logic [31:0] rd_mux;

  // ===========================================================
  // Micro-program: {op, dest, src a, src b}
  function automatic logic [13:0] rom(input logic [6:0] a);
    logic [13:0] w;
    w = {U_END, 12'h000};
    unique case (a)
      7'd0: w = {U_MUL, `R_T1, `R_PX, `R_PX};
      7'd1: w = {U_MUL, `R_T1, `R_T1, `R_PX};
      7'd2: w = {U_ADD, `R_T2, `R_PX, `R_PX};
      7'd3: w = {U_ADD, `R_T2, `R_T2, `R_PX};
      7'd4: w = {U_SUB, `R_T1, `R_T1, `R_T2};
      7'd5: w = {U_ADD, `R_T1, `R_T1, `R_B};
      7'd6: w = {U_MUL, `R_T2, `R_PY, `R_PY};
      7'd8: w = {U_MUL, `R_T1, `R_K, `R_K};
      7'd9: w = {U_MUL, `R_T2, `R_T1, `R_T1};
      7'd10: w = {U_MUL, `R_T3, `R_T2, `R_T1};
      7'd11: w = {U_MUL, `R_T3, `R_T3, `R_B};
      7'd12: w = {U_MUL, `R_T2, `R_T2, `R_PX};
      7'd13: w = {U_ADD, `R_T1, `R_T2, `R_T2};
      7'd14: w = {U_ADD, `R_T1, `R_T1, `R_T2};
      7'd15: w = {U_MUL, `R_T2, `R_PX, `R_PX};
      7'd16: w = {U_MUL, `R_T2, `R_T2, `R_PX};
      7'd17: w = {U_SUB, `R_T2, `R_T2, `R_T1};
      7'd18: w = {U_ADD, `R_T2, `R_T2, `R_T3};
      7'd19: w = {U_MUL, `R_T1, `R_PY, `R_PY};
      7'd21: w = {U_ADD, `R_X, `R_PX, `R_0};
      7'd22: w = {U_ADD, `R_Y, `R_PY, `R_0};
      7'd23: w = {U_ADD, `R_Z, `R_1, `R_0};
      7'd25: w = {U_MUL, `R_T1, `R_Z, `R_Z};
      7'd26: w = {U_SUB, `R_T2, `R_X, `R_T1};
      7'd27: w = {U_ADD, `R_T3, `R_X, `R_T1};
      7'd28: w = {U_MUL, `R_T2, `R_T2, `R_T3};
      7'd29: w = {U_ADD, `R_T3, `R_T2, `R_T2};
      7'd30: w = {U_ADD, `R_T2, `R_T2, `R_T3};
      7'd31: w = {U_MUL, `R_Z, `R_Y, `R_Z};
      7'd32: w = {U_ADD, `R_Z, `R_Z, `R_Z};
      7'd33: w = {U_MUL, `R_Y, `R_Y, `R_Y};
      7'd34: w = {U_MUL, `R_T3, `R_Y, `R_X};
      7'd35: w = {U_ADD, `R_T3, `R_T3, `R_T3};
      7'd36: w = {U_ADD, `R_T3, `R_T3, `R_T3};
      7'd37: w = {U_MUL, `R_X, `R_T2, `R_T2};
      7'd38: w = {U_SUB, `R_X, `R_X, `R_T3};
      7'd39: w = {U_SUB, `R_X, `R_X, `R_T3};
      7'd40: w = {U_SUB, `R_T3, `R_T3, `R_X};
      7'd41: w = {U_MUL, `R_T3, `R_T2, `R_T3};
      7'd42: w = {U_MUL, `R_Y, `R_Y, `R_Y};
      7'd43: w = {U_ADD, `R_Y, `R_Y, `R_Y};
      7'd44: w = {U_ADD, `R_Y, `R_Y, `R_Y};
      7'd45: w = {U_ADD, `R_Y, `R_Y, `R_Y};
      7'd46: w = {U_SUB, `R_Y, `R_T3, `R_Y};
      7'd48: w = {U_MUL, `R_T1, `R_Z, `R_Z};
      7'd49: w = {U_MUL, `R_T2, `R_T1, `R_Z};
      7'd50: w = {U_MUL, `R_T1, `R_T1, `R_PX};
      7'd51: w = {U_MUL, `R_T2, `R_T2, `R_PY};
      7'd52: w = {U_SUB, `R_T1, `R_T1, `R_X};
      7'd53: w = {U_SUB, `R_T2, `R_T2, `R_Y};
      7'd54: w = {U_MUL, `R_Z, `R_Z, `R_T1};
      7'd55: w = {U_MUL, `R_T3, `R_T1, `R_T1};
      7'd56: w = {U_MUL, `R_T1, `R_T3, `R_T1};
      7'd57: w = {U_MUL, `R_T3, `R_T3, `R_X};
      7'd58: w = {U_MUL, `R_X, `R_T2, `R_T2};
      7'd59: w = {U_SUB, `R_X, `R_X, `R_T1};
      7'd60: w = {U_SUB, `R_X, `R_X, `R_T3};
      7'd61: w = {U_SUB, `R_X, `R_X, `R_T3};
      7'd62: w = {U_SUB, `R_T3, `R_T3, `R_X};
      7'd63: w = {U_MUL, `R_T3, `R_T2, `R_T3};
      7'd64: w = {U_MUL, `R_T1, `R_Y, `R_T1};
      7'd65: w = {U_SUB, `R_Y, `R_T3, `R_T1};
      7'd67: w = {U_ADD, `R_T1, `R_1, `R_0};
      7'd68: w = {U_ADD, `R_T2, `R_Z, `R_0};
      7'd70: w = {U_ADD, `R_T1, `R_1, `R_0};
      7'd71: w = {U_ADD, `R_T2, `R_K, `R_0};
      7'd73: w = {U_MUL, `R_T1, `R_T1, `R_T1};
      7'd75: w = {U_MUL, `R_T1, `R_T1, `R_T2};
      7'd77: w = {U_MUL, `R_T2, `R_T1, `R_T1};
      7'd78: w = {U_MUL, `R_PX, `R_X, `R_T2};
      7'd79: w = {U_MUL, `R_T2, `R_T2, `R_T1};
      7'd80: w = {U_MUL, `R_PY, `R_Y, `R_T2};
      7'd82: w = {U_ADD, `R_K, `R_Z, `R_0};
      7'd83: w = {U_ADD, `R_PX, `R_X, `R_0};
      7'd84: w = {U_ADD, `R_PY, `R_Y, `R_0};
      7'd86: w = {U_ADD, `R_K, `R_0, `R_0};
      7'd87: w = {U_ADD, `R_PX, `R_0, `R_0};
      7'd88: w = {U_ADD, `R_PY, `R_0, `R_0};
      7'd90: w = {U_MUL, `R_PY, `R_PY, `R_T1};
      default: w = {U_END, 12'h000};
    endcase
    return w;
  endfunction

  function automatic logic [255:0] fetch(input logic [3:0] i);
    unique case (i)
      `R_0: return '0;
      `R_1: return 256'h1;
      `R_B: return curve_size_select ? `B_256 : `B_192;
      default: return (i < 4'(`N_STORE)) ? store[i] : '0;
    endcase
  endfunction

  function automatic logic [1:0] mem_sel_of(input logic [11:0] a);
    if (a[11:5] == 7'(`OFS_MEM_K >> 5)) return 2'h0;
    if (a[11:5] == 7'(`OFS_MEM_X >> 5)) return 2'h1;
    if (a[11:5] == 7'(`OFS_MEM_Y >> 5)) return 2'h2;
    return `MEM_NONE;
  endfunction

  // ===========================================================
  // Datapath
  // Curve picks modulus and width
  always_comb begin
    p_mod = curve_size_select ? `P_256 : `P_192;
    p_exp = curve_size_select ? `E_256 : `E_192;
    top_bit = curve_size_select ? `TOP_256 : `TOP_192;
    uword = rom(pc);
    alu_op = alu_op_t'(uword[13:12]);
    u_dst = uword[11:8];
    opa = fetch(uword[7:4]);
    opb = fetch(uword[3:0]);
  end

  assign mem_sel = mem_sel_of(addr);
  assign mem_wr = wr_en && mem_sel != `MEM_NONE && state == ST_IDLE;
  assign abort = wr_en && addr == `OFS_CONF && wdata[`CONF_RESET];
  assign launch = wr_en && addr == `OFS_CONF && wdata[`CONF_START] &&
                  !wdata[`CONF_RESET] && state == ST_IDLE;
  // Busy reads back as start bit
  assign launch_bit = state != ST_IDLE;
  assign done_pulse = state == ST_DONE;
  assign alu_start = state == ST_EXEC && !issued && alu_op != U_END;
  assign ver_eq = store[`R_T1] == store[`R_T2];
  assign kbit = store[`R_K][bit_idx];

  ecc_mod_alu u_alu (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(abort),
    .start(alu_start),
    .op(alu_op),
    .a(opa),
    .b(opb),
    .modulus(p_mod),
    .done(alu_done),
    .result(alu_res)
  );

  // Word n sits at bits 32n+31..32n
  always_ff @(posedge clk) begin
    if (alu_done && state == ST_EXEC && issued) begin
      store[u_dst] <= alu_res;
    end else if (mem_wr) begin
      store[mem_sel][{addr[4:2], 5'h00} +: 32] <= wdata;
    end
  end

  // ===========================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      state <= ST_IDLE;
      ret_state <= ST_IDLE;
      pc <= 7'd0;
      post_pc <= 7'd0;
      issued <= 1'b0;
      inf <= 1'b1;
      do_mult <= 1'b0;
      jac_out <= 1'b0;
      bit_idx <= 8'd0;
    end else begin
      unique case (state)
        ST_IDLE: if (launch) begin
          do_mult <= wdata[6:4] inside {`OP_PMUL, `OP_VER_MUL, `OP_JMUL,
                                        `OP_VER_JMUL};
          // Jacobian output flag from code bit 2: set for codes 4 to 7
          jac_out <= wdata[6];
          bit_idx <= wdata[`CONF_CURVE] ? `TOP_256 : `TOP_192;
          unique case (wdata[6:4])
            `OP_VER, `OP_VER_MUL, `OP_VER_JMUL: begin
              pc <= `SEG_VA;
              ret_state <= ST_CHECK;
              state <= ST_EXEC;
            end
            // Jacobian check on X, Y, Z
            `OP_JVER: begin
              pc <= `SEG_VJ;
              ret_state <= ST_CHECK;
              state <= ST_EXEC;
            end
            `OP_PMUL, `OP_JMUL: state <= ST_MSTART;
            `OP_DIV: begin
              pc <= `SEG_INVK;
              post_pc <= `SEG_DIVF;
              ret_state <= ST_INV;
              state <= ST_EXEC;
            end
            `OP_RSVD: state <= ST_DONE;
          endcase
        end
        ST_EXEC: if (!issued) begin
          if (alu_op == U_END) state <= ret_state;
          else issued <= 1'b1;
        end else if (alu_done) begin
          issued <= 1'b0;
          pc <= pc + 7'd1;
        end
        // Multiply only when point is valid
        ST_CHECK: state <= (ver_eq && do_mult) ? ST_MSTART : ST_DONE;
        ST_MSTART: begin
          inf <= 1'b1;
          bit_idx <= top_bit;
          state <= ST_BIT;
        end
        // First set bit loads (x, y, 1)
        ST_BIT: if (inf) begin
          if (kbit) begin
            inf <= 1'b0;
            pc <= `SEG_LOADP;
            ret_state <= ST_NEXT;
            state <= ST_EXEC;
          end else begin
            state <= ST_NEXT;
          end
        end else begin
          pc <= `SEG_DBL;
          ret_state <= ST_DBLD;
          state <= ST_EXEC;
        end
        ST_DBLD: if (kbit) begin
          pc <= `SEG_ADD;
          ret_state <= ST_NEXT;
          state <= ST_EXEC;
        end else begin
          state <= ST_NEXT;
        end
        ST_NEXT: if (bit_idx == 8'd0) begin
          state <= ST_MEND;
        end else begin
          bit_idx <= bit_idx - 8'd1;
          state <= ST_BIT;
        end
        ST_MEND: begin
          state <= ST_EXEC;
          ret_state <= ST_DONE;
          if (inf) begin
            pc <= jac_out ? `SEG_ZK : `SEG_ZXY;
          end else if (jac_out) begin
            pc <= `SEG_STJ;
          end else begin
            pc <= `SEG_INVZ;
            post_pc <= `SEG_AFF;
            ret_state <= ST_INV;
            bit_idx <= top_bit;
          end
        end
        ST_INV: begin
          pc <= `SEG_SQ;
          ret_state <= ST_INVM;
          state <= ST_EXEC;
        end
        ST_INVM: if (p_exp[bit_idx]) begin
          pc <= `SEG_MB;
          ret_state <= ST_INVN;
          state <= ST_EXEC;
        end else begin
          state <= ST_INVN;
        end
        ST_INVN: if (bit_idx == 8'd0) begin
          pc <= post_pc;
          ret_state <= ST_DONE;
          state <= ST_EXEC;
        end else begin
          bit_idx <= bit_idx - 8'd1;
          state <= ST_INV;
        end
        ST_DONE: state <= ST_IDLE;
      endcase
    end
  end

  // ===========================================================
  // Registers and interrupt
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      curve_size_select <= `CURVE_192;
      operation_select <= `OP_PMUL;
      clk_force <= 1'b0;
      int_ena <= 1'b0;
      date_word <= `DATE_RESET;
    end else if (wr_en) begin
      unique case (addr)
        `OFS_CONF: begin
          clk_force <= wdata[`CONF_CLK_EN];
          if (state == ST_IDLE) begin
            curve_size_select <= wdata[`CONF_CURVE];
            operation_select <= wdata[6:4];
          end
        end
        `OFS_INT_ENA: int_ena <= wdata[`INT_DONE];
        `OFS_DATE: date_word <= wdata;
        default: ;
      endcase
    end
  end

  // Result cleared at launch, set at check
  always_ff @(posedge clk) begin
    if (sys_rst || launch || abort) on_curve_result <= 1'b0;
    else if (state == ST_CHECK) on_curve_result <= ver_eq;
  end

  // Completion sets raw; set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_raw <= 1'b0;
      calc_complete_irq <= 1'b0;
    end else begin
      if (done_pulse) int_raw <= 1'b1;
      else if ((wr_en && addr == `OFS_INT_CLR && wdata[`INT_DONE]) ||
               (rd_en && addr == `OFS_INT_RAW)) int_raw <= 1'b0;
      calc_complete_irq <= int_raw && int_ena;
    end
  end

  // Operand words read back in place
  always_comb begin
    rd_mux = 32'h0;
    unique case (addr)
      `OFS_INT_RAW: rd_mux = {31'h0, int_raw};
      `OFS_INT_ST: rd_mux = {31'h0, int_raw && int_ena};
      `OFS_INT_ENA: rd_mux = {31'h0, int_ena};
      `OFS_CONF: rd_mux = {24'h0, on_curve_result, operation_select,
                           clk_force, curve_size_select, 1'b0, launch_bit};
      `OFS_DATE: rd_mux = date_word;
      default: if (mem_sel != `MEM_NONE)
        rd_mux = store[mem_sel][{addr[4:2], 5'h00} +: 32];
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) rdata <= 32'h0;
    else rdata <= rd_en ? rd_mux : 32'h0;
  end

  // ===========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_launch_op(logic [2:0] c);
    launch && wdata[6:4] == c;
  endsequence
  sequence s_quick_end;
    done_pulse ##1 !launch_bit;
  endsequence

  property p_curve_top;
    launch && wdata[`CONF_CURVE] |=> bit_idx == 8'd255;
  endproperty
  a_curve_top: assert property (p_curve_top)
    else $error("256-bit curve did not start at bit 255");
  property p_reserved;
    s_launch_op(`OP_RSVD) |=> s_quick_end;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved operation did not finish at once");
  property p_read_idle;
    !rd_en |=> rdata == 32'h0;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data present without a read");
  property p_check_report;
    state == ST_CHECK |=> on_curve_result == $past(ver_eq);
  endproperty
  a_check_report: assert property (p_check_report)
    else $error("check outcome not reported");
  property p_fail_skip;
    state == ST_CHECK && !ver_eq |=> done_pulse ##1 !launch_bit;
  endproperty
  a_fail_skip: assert property (p_fail_skip)
    else $error("multiply ran after a failed check");
  property p_jac_after_check;
    state == ST_CHECK && ver_eq && do_mult && jac_out |=>
      state == ST_MSTART ##1 state == ST_BIT;
  endproperty
  a_jac_after_check: assert property (p_jac_after_check)
    else $error("valid point did not enter the multiply");
  property p_launch_busy;
    launch |=> launch_bit;
  endproperty
  a_launch_busy: assert property (p_launch_busy)
    else $error("start bit not set by launch");
  property p_self_clear;
    done_pulse |=> !launch_bit && int_raw;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("start bit not cleared at completion");
  property p_irq_level;
    (int_raw && int_ena) [*2] |-> calc_complete_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("enabled raw status did not raise the interrupt");
  property p_clear;
    wr_en && addr == `OFS_INT_CLR && wdata[`INT_DONE] && !done_pulse
      |=> !int_raw ##1 !calc_complete_irq;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear bit did not clear status and interrupt");
  property p_result_fresh;
    launch |=> !on_curve_result;
  endproperty
  a_result_fresh: assert property (p_result_fresh)
    else $error("stale result visible after launch");
endmodule // ecc_point_engine
`default_nettype wire

// file: tb/ecc_point_engine_tb.sv
// Self-checking bench for the elliptic-curve point engine
`timescale 1ns/1ps
`default_nettype none
module ecc_point_engine_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_d = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic calc_complete_irq;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] mem[24];
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  // Base point of the 192-bit curve
  localparam logic [255:0] GX =
    256'h188da80eb03090f67cbf20eb43a18800f4ff0afd82ff1012;
  localparam logic [255:0] GY =
    256'h07192b95ffc8da78631011ed6b24cdd573f977a11e794811;

  always #10 clk = ~clk;

  ecc_point_engine u_ecc_point_engine (
    .clk(clk),
    .sys_rst(sys_rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .calc_complete_irq(calc_complete_irq)
  );

  // ==========================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Read data monitor and cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(rdata & e[63:32], e[31:0]);
    end
    rd_d <= rd_en;
    if (cyc == 90000) begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================
  // Bus cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] w,
                    input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back({m, w & m});
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic load(input logic [11:0] b, input logic [255:0] v);
    for (int n = 0; n < 8; n++)
      wr(b + 12'(4 * n), v[32 * n +: 32]);
  endtask

  // Launch, wait for completion, check result and interrupt
  task automatic run(input logic [2:0] op, input logic cv, input logic res);
    wr(12'h01c, {24'h0, 1'b0, op, 1'b0, cv, 2'b01});
    rd(12'h01c, 32'h1, 32'h1);
    for (int i = 0; i < 40000 && calc_complete_irq !== 1'b1; i++)
      @(posedge clk);
    rd(12'h01c, {24'h0, res, op, 1'b0, cv, 2'b00}, 32'hf5);
    rd(12'h00c, 32'h1, 32'h1);
    @(posedge clk);
    check({31'h0, calc_complete_irq}, 32'h0);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(54));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(12'h01c, 32'h0, 32'hff);
    rd(12'h0fc, 32'h1, '1);
    rd(12'h160, 32'h0, '1);
    for (int i = 0; i < 24; i++) begin
      mem[i] = $urandom;
      wr(12'h100 + 12'(4 * i), mem[i]);
    end
    for (int i = 0; i < 24; i++)
      rd(12'h100 + 12'(4 * i), mem[i], '1);
    wr(12'h014, 32'h1);
    load(12'h120, GX);
    load(12'h140, GY);
    run(3'd2, 1'b0, 1'b1);
    run(3'd2, 1'b1, 1'b0);
    rd(12'h120, GX[31:0], '1);
    wr(12'h140, GY[31:0] + 32'h1);
    run(3'd2, 1'b0, 1'b0);
    run(3'd3, 1'b0, 1'b0);
    run(3'd7, 1'b0, 1'b0);
    rd(12'h144, GY[63:32], '1);
    rd(12'h140, GY[31:0] + 32'h1, '1);
    wr(12'h140, GY[31:0]);
    // Scalar 2: one doubling, Z becomes twice y
    load(12'h100, 256'h2);
    run(3'd4, 1'b0, 1'b0);
    rd(12'h100, 32'h3cf29022, '1);
    run(3'd6, 1'b0, 1'b1);
    // Valid point, scalar 1: check passes, Jacobian copy out
    load(12'h120, GX);
    load(12'h140, GY);
    load(12'h100, 256'h1);
    run(3'd7, 1'b0, 1'b1);
    rd(12'h100, 32'h1, '1);
    rd(12'h120, GX[31:0], '1);
    // Scalar 0 gives the point at infinity
    wr(12'h100, 32'h0);
    run(3'd0, 1'b0, 1'b0);
    rd(12'h124, 32'h0, '1);
    rd(12'h140, 32'h0, '1);
    // Reserved code with the interrupt masked
    wr(12'h014, 32'h0);
    wr(12'h01c, 32'h51);
    repeat (6) @(posedge clk);
    check({31'h0, calc_complete_irq}, 32'h0);
    rd(12'h010, 32'h0, '1);
    rd(12'h01c, 32'h50, 32'hf5);
    wr(12'h014, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, calc_complete_irq}, 32'h1);
    wr(12'h018, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, calc_complete_irq}, 32'h0);
    rd(12'h00c, 32'h0, '1);
    end_of_test();
  end
endmodule // ecc_point_engine_tb
`default_nettype wire
